// ==== log_framer_cfg.svh ====
// constants of the measurement log buffer and frame builder
`ifndef LOG_FRAMER_CFG_SVH
`define LOG_FRAMER_CFG_SVH

// ************************************************************
// register offsets (byte addresses on the apb bus)
// ************************************************************
`define OFS_CTRL 8'h00
`define OFS_PERIOD 8'h04
`define OFS_FETCH 8'h08
`define OFS_STATUS 8'h0c
`define OFS_SEQ 8'h10

// ************************************************************
// log state command values and field positions
// ************************************************************
`define LOG_OFF 2'h0
`define LOG_USB 2'h1
`define LOG_CTRL 2'h2
`define ST_ACTIVE_BIT 0
`define ST_MODE_LSB 1
`define ST_BUSY_BIT 3
`define ST_COUNT_LSB 16

// ************************************************************
// buffer sizes and frame constants
// ************************************************************
`define BUF_MAX 14'h1f40
`define FETCH_MAX 14'h03e8
`define SEQ_MAX 32'h773593ff
`define CODE_START 8'h23
`define CODE_DIGITS 8'h38
`define CODE_END 8'h0a
`define ASCII_ZERO_HI 4'h3
`define HDR_LAST 5'h1b
`define REC_LAST 4'hb
`define LEN_BASE_BCD 32'h00000018
`define PERIOD_RST 32'h000003e8

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS 40
`define MS_TIME_NS 1000000
`define CYC_PER_MS (`MS_TIME_NS / `CLK_PERIOD_NS)
`define BLINK_MS 16'h01f4

`endif

// ==== log_framer_pkg.sv ====
// types shared by the log buffer framer
package log_framer_pkg;
	typedef enum logic [3:0] {
		S_IDLE, S_SUM_RD, S_SUM_WAIT, S_SUM_BYTE, S_HDR, S_REC_RD, S_REC_WAIT, S_REC_BYTE, S_END
	} frame_state_t;
endpackage

// ==== record_mem.sv ====
// simple dual port record store with registered read data
`timescale 1ns/100ps
module record_mem #(
	parameter int WIDTH = 96,
	parameter int DEPTH = 8000,
	parameter int AW = 13
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	initial begin
		if (DEPTH > (1 << AW) || DEPTH < 2)
			$error("record_mem: depth does not fit address width");
	end

	always_ff @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule // record_mem

// ==== measurement_log_buffer_framer.sv ====
// measurement log buffer with binary block frame builder and apb registers
// Functional notes
// [R01] buffer holds up to 8000 records while logging
// [R02] one fetch returns at most 1000 records
// [R03] log state 2 or 1 starts logging
// [R04] log state 0 or panel stop ends logging; panel stop is ignored while remote_flag is high
// [R05] fetched records leave the buffer
// [R06] fetch answered only while logging is active
// [R07] overflow past 8000 drops oldest 1000
// [R08] controller fetches before buffer reaches 8000
// [R09] stopping clears all buffered records
// [R10] frame fields in fixed order, no separators
// [R11] first byte is start code 0x23
// [R12] digit count '8' then eight ascii digits
// [R13] two reserved bytes are zero
// [R14] checksum sums bytes after it, lsb first
// [R15] sequence counts fetches, wraps, restarts at zero
// [R16] sample period in ms, lsb first
// [R17] record count field, lsb first
// [R18] records oldest first: status, voltage, current
// [R19] status word sent lowest byte first
// [R20] voltage mv and current ma, lsb first
// [R21] last byte is end code 0x0a
// [R22] empty fetch gives zero fields, no records
// [R23] status bit map, cv set with cp
// [R24] one record captured per sample period
`timescale 1ns/100ps
`include "log_framer_cfg.svh"
module measurement_log_buffer_framer import log_framer_pkg::*; #(
	parameter int CYC_PER_MS = `CYC_PER_MS,
	parameter int BUF_DEPTH = 8000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic panel_stop,
	input wire logic cal_flag,
	input wire logic lock_flag,
	input wire logic output_on_flag,
	input wire logic remote_flag,
	input wire logic constant_voltage_flag,
	input wire logic constant_power_flag,
	input wire logic constant_current_flag,
	input wire logic overvoltage_trip_flag,
	input wire logic overcurrent_trip_flag,
	input wire logic overtemp_trip_flag,
	input wire logic undervoltage_trip_flag,
	input wire logic [31:0] meas_voltage_mv,
	input wire logic [31:0] meas_current_ma,
	output logic [7:0] frame_data,
	output logic frame_valid,
	output logic frame_last,
	input wire logic frame_ready,
	output logic activity_lamp
);
	initial begin
		if (BUF_DEPTH != 8000 || CYC_PER_MS < 2)
			$error("log framer: unsupported parameter values");
	end

	// ************************************************************
	// state
	// ************************************************************
	logic [1:0] mode_reg;
	logic [31:0] period_reg;
	logic [31:0] seq_reg;
	logic [13:0] count_reg;
	logic [12:0] rd_ptr_reg;
	logic [12:0] wr_ptr_reg;
	frame_state_t state_reg;
	logic [12:0] fptr_reg;
	logic [13:0] n_reg;
	logic [13:0] left_reg;
	logic [4:0] idx_reg;
	logic [31:0] cks_reg;
	logic [31:0] len_bcd_reg;
	logic [31:0] fseq_reg;
	logic [31:0] fper_reg;
	logic [95:0] rec_reg;
	logic [95:0] rdata;
	logic [15:0] out_pos_reg;
	logic ack_reg;
	logic [31:0] ms_cnt_reg;
	logic [31:0] smp_cnt_reg;
	logic [15:0] blink_cnt_reg;
	logic blink_reg;
	logic active;
	logic busy;
	logic wr_access;
	logic fetch_go;
	logic start_cmd;
	logic stop_cmd;
	logic ms_tick;
	logic sample;
	logic discard;
	logic [13:0] take;
	logic load;
	logic emit_en;
	logic emit_last;
	logic [7:0] emit_byte;
	logic [31:0] hdr_word;
	logic [2:0] dsel;
	logic [31:0] status_word;

	assign active = (mode_reg != `LOG_OFF);
	assign busy = (state_reg != S_IDLE);
	assign wr_access = psel && penable && pwrite;
	assign start_cmd = wr_access && paddr == `OFS_CTRL && !active
		&& (pwdata[1:0] == `LOG_CTRL || pwdata[1:0] == `LOG_USB); // [R03]
	assign stop_cmd = active && ((wr_access && paddr == `OFS_CTRL && pwdata[1:0] == `LOG_OFF)
		|| (panel_stop && !remote_flag)); // [R04]
	assign fetch_go = wr_access && paddr == `OFS_FETCH && active && !busy; // [R06]
	assign take = (count_reg > `FETCH_MAX) ? `FETCH_MAX : count_reg; // [R02]

	function automatic logic [12:0] ptr_add(input logic [12:0] p, input logic [13:0] k);
		logic [14:0] s;
		s = {2'h0, p} + {1'h0, k};
		if (s >= {1'h0, `BUF_MAX})
			s = s - {1'h0, `BUF_MAX};
		return s[12:0];
	endfunction

	function automatic logic [31:0] byte_sum(input logic [31:0] v);
		return 32'(v[7:0]) + 32'(v[15:8]) + 32'(v[23:16]) + 32'(v[31:24]);
	endfunction

	function automatic logic [31:0] bcd_inc(input logic [31:0] v);
		logic [31:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (c) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// ************************************************************
	// apb slave: one wait-free access phase, read data from a flop
	// ************************************************************
	assign pready = psel && penable && ack_reg;
	assign pslverr = pready && !(paddr == `OFS_CTRL || paddr == `OFS_PERIOD
		|| paddr == `OFS_FETCH || paddr == `OFS_STATUS || paddr == `OFS_SEQ);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			prdata <= 32'h0;
		end else begin
			ack_reg <= psel && !penable;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`OFS_CTRL: prdata <= {30'h0, mode_reg};
					`OFS_PERIOD: prdata <= period_reg;
					`OFS_STATUS: prdata <= {2'h0, count_reg, 12'h0, busy, mode_reg, active};
					`OFS_SEQ: prdata <= seq_reg;
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_reg <= `LOG_OFF;
			period_reg <= `PERIOD_RST;
		end else begin
			if (start_cmd)
				mode_reg <= pwdata[1:0]; // [R03]
			else if (stop_cmd)
				mode_reg <= `LOG_OFF; // [R04]
			if (wr_access && paddr == `OFS_PERIOD && !active)
				period_reg <= pwdata;
		end
	end

	// ************************************************************
	// sample timing and activity lamp
	// ************************************************************
	assign ms_tick = (ms_cnt_reg == 32'(CYC_PER_MS - 1));
	assign sample = active && ms_tick && period_reg != 32'h0
		&& smp_cnt_reg >= period_reg - 32'h1; // [R24]

	always_ff @(posedge clk) begin
		if (!rst_n || !active) begin
			ms_cnt_reg <= 32'h0;
			smp_cnt_reg <= 32'h0;
		end else begin
			ms_cnt_reg <= ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
			if (sample)
				smp_cnt_reg <= 32'h0;
			else if (ms_tick)
				smp_cnt_reg <= smp_cnt_reg + 32'h1;
		end
	end

	// lamp blinks while logging and stays lit once stopped
	always_ff @(posedge clk) begin
		if (!rst_n || !active) begin
			blink_cnt_reg <= 16'h0;
			blink_reg <= 1'b1;
		end else if (ms_tick) begin
			blink_cnt_reg <= (blink_cnt_reg == `BLINK_MS - 16'h1) ? 16'h0 : blink_cnt_reg + 16'h1;
			if (blink_cnt_reg == `BLINK_MS - 16'h1)
				blink_reg <= !blink_reg;
		end
	end
	assign activity_lamp = blink_reg; // [R04]

	// ************************************************************
	// record buffer bookkeeping
	// ************************************************************
	always_comb begin
		status_word = 32'h0;
		status_word[0] = cal_flag;
		status_word[1] = lock_flag;
		status_word[3] = output_on_flag;
		status_word[4] = remote_flag;
		status_word[8] = constant_voltage_flag || constant_power_flag; // [R23]
		status_word[9] = constant_power_flag;
		status_word[10] = constant_current_flag;
		status_word[16] = overvoltage_trip_flag;
		status_word[17] = overcurrent_trip_flag;
		status_word[20] = overtemp_trip_flag;
		status_word[30] = undervoltage_trip_flag;
	end

	assign discard = sample && (count_reg - (fetch_go ? take : 14'h0)) == `BUF_MAX; // [R07]

	// fetched records leave the buffer at once; the frame reads them
	// from a snapshot pointer, safe since a refill takes far longer
	always_ff @(posedge clk) begin
		if (!rst_n || stop_cmd || start_cmd) begin
			count_reg <= 14'h0; // [R09]
			rd_ptr_reg <= 13'h0;
			wr_ptr_reg <= 13'h0;
		end else begin
			count_reg <= count_reg - (fetch_go ? take : 14'h0) + (sample ? 14'h1 : 14'h0)
				- (discard ? `FETCH_MAX : 14'h0); // [R05] [R07]
			rd_ptr_reg <= ptr_add(rd_ptr_reg, (fetch_go ? take : 14'h0)
				+ (discard ? `FETCH_MAX : 14'h0));
			if (sample)
				wr_ptr_reg <= ptr_add(wr_ptr_reg, 14'h1); // [R01]
		end
	end

	record_mem #(.WIDTH(96), .DEPTH(BUF_DEPTH), .AW(13)) record_mem_inst (
		.clk(clk),
		.we(sample),
		.waddr(wr_ptr_reg),
		.wdata({meas_current_ma, meas_voltage_mv, status_word}), // [R18] [R20]
		.raddr(fptr_reg),
		.rdata(rdata)
	);

	always_ff @(posedge clk) begin
		if (!rst_n || start_cmd)
			seq_reg <= 32'h0; // [R15]
		else if (fetch_go)
			seq_reg <= (seq_reg == `SEQ_MAX) ? 32'h0 : seq_reg + 32'h1; // [R15]
	end

	// ************************************************************
	// frame builder: checksum pass, then byte emission
	// ************************************************************
	assign load = !frame_valid || frame_ready;
	assign dsel = 3'(5'h9 - idx_reg);

	always_comb begin
		unique case (idx_reg[4:2])
			3'h3: hdr_word = cks_reg; // [R14]
			3'h4: hdr_word = fseq_reg; // [R15]
			3'h5: hdr_word = fper_reg; // [R16]
			default: hdr_word = {18'h0, n_reg}; // [R17]
		endcase
	end

	always_comb begin
		emit_en = 1'b0;
		emit_last = 1'b0;
		emit_byte = 8'h0;
		if (state_reg == S_HDR) begin
			emit_en = 1'b1;
			if (idx_reg == 5'h0)
				emit_byte = `CODE_START; // [R11]
			else if (idx_reg == 5'h1)
				emit_byte = `CODE_DIGITS; // [R12]
			else if (idx_reg <= 5'h9)
				emit_byte = {`ASCII_ZERO_HI, len_bcd_reg[dsel*4 +: 4]}; // [R12]
			else if (idx_reg <= 5'hb)
				emit_byte = 8'h0; // [R13]
			else
				emit_byte = hdr_word[idx_reg[1:0]*8 +: 8]; // [R10]
		end else if (state_reg == S_REC_BYTE) begin
			emit_en = 1'b1;
			emit_byte = rec_reg[idx_reg[3:0]*8 +: 8]; // [R18] [R19] [R20]
		end else if (state_reg == S_END) begin
			emit_en = 1'b1;
			emit_last = 1'b1;
			emit_byte = `CODE_END; // [R21]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_valid <= 1'b0;
			frame_last <= 1'b0;
			frame_data <= 8'h0;
			out_pos_reg <= 16'h0;
		end else if (fetch_go) begin
			out_pos_reg <= 16'h0;
		end else if (load) begin
			frame_valid <= emit_en;
			frame_last <= emit_last;
			frame_data <= emit_byte;
			if (emit_en)
				out_pos_reg <= out_pos_reg + 16'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			fptr_reg <= 13'h0;
			n_reg <= 14'h0;
			left_reg <= 14'h0;
			idx_reg <= 5'h0;
			cks_reg <= 32'h0;
			len_bcd_reg <= 32'h0;
			fseq_reg <= 32'h0;
			fper_reg <= 32'h0;
			rec_reg <= 96'h0;
		end else begin
			unique case (state_reg)
				S_IDLE: if (fetch_go) begin
					fptr_reg <= rd_ptr_reg;
					n_reg <= take;
					left_reg <= take;
					idx_reg <= 5'h0;
					len_bcd_reg <= `LEN_BASE_BCD;
					// empty frame: every field between the length and the end code is zero
					fseq_reg <= (take == 14'h0) ? 32'h0 : seq_reg; // [R22]
					fper_reg <= (take == 14'h0) ? 32'h0 : period_reg; // [R22]
					cks_reg <= (take == 14'h0) ? 32'h0
						: byte_sum(seq_reg) + byte_sum(period_reg) + byte_sum({18'h0, take}); // [R14]
					state_reg <= (take == 14'h0) ? S_HDR : S_SUM_RD;
				end
				S_SUM_RD: state_reg <= S_SUM_WAIT;
				S_SUM_WAIT: begin
					rec_reg <= rdata;
					state_reg <= S_SUM_BYTE;
				end
				S_SUM_BYTE: begin
					cks_reg <= cks_reg + 32'(rec_reg[idx_reg[3:0]*8 +: 8]); // [R14]
					len_bcd_reg <= bcd_inc(len_bcd_reg); // [R12]
					idx_reg <= idx_reg + 5'h1;
					if (idx_reg[3:0] == `REC_LAST) begin
						idx_reg <= 5'h0;
						fptr_reg <= ptr_add(fptr_reg, 14'h1);
						left_reg <= left_reg - 14'h1;
						if (left_reg == 14'h1) begin
							// rewind for the emission pass
							fptr_reg <= ptr_add(fptr_reg, `BUF_MAX - n_reg + 14'h1);
							left_reg <= n_reg;
							state_reg <= S_HDR;
						end else begin
							state_reg <= S_SUM_RD;
						end
					end
				end
				S_HDR: if (load) begin
					idx_reg <= idx_reg + 5'h1;
					if (idx_reg == `HDR_LAST) begin
						idx_reg <= 5'h0;
						state_reg <= (n_reg == 14'h0) ? S_END : S_REC_RD; // [R10]
					end
				end
				S_REC_RD: state_reg <= S_REC_WAIT;
				S_REC_WAIT: begin
					rec_reg <= rdata;
					state_reg <= S_REC_BYTE;
				end
				S_REC_BYTE: if (load) begin
					idx_reg <= idx_reg + 5'h1;
					if (idx_reg[3:0] == `REC_LAST) begin
						idx_reg <= 5'h0;
						fptr_reg <= ptr_add(fptr_reg, 14'h1); // [R18]
						left_reg <= left_reg - 14'h1;
						state_reg <= (left_reg == 14'h1) ? S_END : S_REC_RD;
					end
				end
				S_END: if (load)
					state_reg <= S_IDLE;
			endcase
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence frame_open_s;
		fetch_go ##1 busy;
	endsequence

	buf_bound_a: assert property (count_reg <= `BUF_MAX) // [R01]
		else $error("buffer count above limit");
	fetch_limit_a: assert property (busy |-> n_reg <= `FETCH_MAX) // [R02]
		else $error("frame holds too many records");
	start_mode_a: assert property (start_cmd |=> active && count_reg <= 14'h1) // [R03]
		else $error("start did not begin logging");
	stop_clear_a: assert property (stop_cmd |=> !active && count_reg == 14'h0) // [R04] [R09]
		else $error("stop did not clear buffer");
	fetch_remove_a: assert property (fetch_go && !sample && !stop_cmd
		|=> count_reg == $past(count_reg) - $past(take)) // [R05]
		else $error("fetched records still counted");
	idle_fetch_a: assert property (wr_access && paddr == `OFS_FETCH && !active && !busy
		|=> !busy) // [R06]
		else $error("frame sent while stopped");
	overflow_drop_a: assert property (discard && !stop_cmd && !start_cmd
		|=> count_reg == `BUF_MAX - `FETCH_MAX + 14'h1) // [R07]
		else $error("overflow did not drop oldest block");
	start_code_a: assert property (frame_valid && out_pos_reg == 16'h1
		|-> frame_data == `CODE_START) // [R11]
		else $error("first byte is not start code");
	digit_code_a: assert property (frame_valid && out_pos_reg == 16'h2
		|-> frame_data == `CODE_DIGITS) // [R12]
		else $error("digit count byte wrong");
	reserved_zero_a: assert property (frame_valid && (out_pos_reg == 16'hb || out_pos_reg == 16'hc)
		|-> frame_data == 8'h0) // [R13]
		else $error("reserved byte not zero");
	end_code_a: assert property (frame_valid && frame_last
		|-> frame_data == `CODE_END && out_pos_reg == 16'(29 + 12 * n_reg)) // [R10] [R21]
		else $error("frame end wrong");
	empty_zero_a: assert property (frame_valid && n_reg == 14'h0 && out_pos_reg > 16'ha
		&& !frame_last |-> frame_data == 8'h0) // [R22]
		else $error("empty frame field not zero");
	seq_step_a: assert property (frame_open_s
		|-> ((n_reg == 14'h0) ? fseq_reg == 32'h0 : fseq_reg == $past(seq_reg))) // [R15]
		else $error("sequence field not taken from counter");
endmodule // measurement_log_buffer_framer

// ==== frame_sink.sv ====
// remote controller model: accepts frame bytes and keeps them for the bench
`timescale 1ns/100ps
module frame_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] frame_data,
	input wire logic frame_valid,
	input wire logic frame_last,
	input wire logic slow,
	output logic frame_ready
);
	// ************************************************************
	// byte capture
	// ************************************************************
	logic [7:0] bytes_q[$];
	int frames_done;
	logic [1:0] ph_reg;
	// slow mode stalls every other cycle so held bytes are exercised
	always @(posedge clk) begin
		if (!rst_n) begin
			ph_reg <= 2'h0;
			frame_ready <= 1'b0;
			frames_done <= 0;
		end else begin
			ph_reg <= ph_reg + 2'h1;
			frame_ready <= !slow || ph_reg[0];
			if (frame_valid && frame_ready) begin
				bytes_q.push_back(frame_data);
				if (frame_last)
					frames_done <= frames_done + 1;
			end
		end
	end
endmodule // frame_sink

// ==== measurement_log_buffer_framer_test.sv ====
// self-checking bench of the log buffer framer
`timescale 1ns/100ps
`include "log_framer_cfg.svh"
module measurement_log_buffer_framer_test;
	// ************************************************************
	// stimulus and instances
	// ************************************************************
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, cnt = 32'h0;
	logic pready, pslverr, er, panel_stop = 1'b0, remote_en = 1'b1, slow = 1'b0;
	logic [7:0] frame_data;
	logic frame_valid, frame_last, frame_ready, activity_lamp, lamp_low = 1'b0;
	int err_count = 0, tests_run = 0, cycles = 0;
	always #20 clk = ~clk;
	// flags and measurements follow a free counter so each record is predictable
	measurement_log_buffer_framer #(.CYC_PER_MS(4)) measurement_log_buffer_framer_inst (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.panel_stop(panel_stop), .cal_flag(cnt[2]), .lock_flag(cnt[3]),
		.output_on_flag(cnt[4]), .remote_flag(cnt[5] & remote_en),
		.constant_voltage_flag(cnt[6]), .constant_power_flag(cnt[7]),
		.constant_current_flag(cnt[8]), .overvoltage_trip_flag(cnt[9]),
		.overcurrent_trip_flag(cnt[10]), .overtemp_trip_flag(cnt[11]),
		.undervoltage_trip_flag(cnt[12]), .meas_voltage_mv(cnt), .meas_current_ma(~cnt),
		.frame_data(frame_data), .frame_valid(frame_valid), .frame_last(frame_last),
		.frame_ready(frame_ready), .activity_lamp(activity_lamp));
	frame_sink frame_sink_inst (.clk(clk), .rst_n(rst_n), .frame_data(frame_data),
		.frame_valid(frame_valid), .frame_last(frame_last), .slow(slow),
		.frame_ready(frame_ready));
	always @(posedge clk) begin
		cnt <= cnt + 32'h1;
		cycles <= cycles + 1;
		if (activity_lamp === 1'b0)
			lamp_low <= 1'b1;
		if (cycles > 100000) begin
			err_count = err_count + 1;
			complete_run();
		end
	end
	// ************************************************************
	// shared tasks
	// ************************************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task complete_run();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// request held until pready is seen high, released after that edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function logic [31:0] w32(input int i);
		return {frame_sink_inst.bytes_q[i+3], frame_sink_inst.bytes_q[i+2],
			frame_sink_inst.bytes_q[i+1], frame_sink_inst.bytes_q[i]};
	endfunction
	function logic [31:0] stat(input logic [31:0] v);
		return {1'h0, v[12], 9'h0, v[11], 2'h0, v[10], v[9], 5'h0, v[8], v[7], v[6] | v[7],
			3'h0, v[5], v[4], 1'h0, v[3], v[2]};
	endfunction
	// issue a fetch and judge the frame against the field layout; sequence and period fields are left to the caller
	task fetch_frame(output int n, output logic [31:0] v0, output logic [31:0] vl);
		int start, k, len, pw, b, sz;
		logic [31:0] s;
		frame_sink_inst.bytes_q.delete();
		start = frame_sink_inst.frames_done;
		apb(1'b1, `OFS_FETCH, 32'h0);
		k = 0;
		while (frame_sink_inst.frames_done == start && k < 40000) begin
			@(posedge clk);
			k++;
		end
		check({31'h0, k < 40000}, 32'h1);
		n = w32(24);
		sz = frame_sink_inst.bytes_q.size();
		check(sz, 29 + 12 * n);
		check({31'h0, n <= 1000}, 32'h1);
		check(frame_sink_inst.bytes_q[0], 32'h23);
		check(frame_sink_inst.bytes_q[1], 32'h38);
		len = 18 + 12 * n;
		pw = 10000000;
		for (int i = 0; i < 8; i++) begin
			check(frame_sink_inst.bytes_q[2+i], 32'h30 + (len / pw) % 10);
			pw = pw / 10;
		end
		check({frame_sink_inst.bytes_q[10], frame_sink_inst.bytes_q[11]}, 32'h0);
		s = 32'h0;
		for (int i = 16; i < sz - 1; i++)
			s = s + frame_sink_inst.bytes_q[i];
		check(w32(12), s);
		check(frame_sink_inst.bytes_q[sz-1], 32'h0a);
		for (int r = 0; r < n; r++) begin
			b = 28 + 12 * r;
			check(w32(b), stat(w32(b + 4)));
			check(w32(b + 8), ~w32(b + 4));
			if (r > 0)
				check(w32(b + 4) - w32(b - 8), 32'h8);
		end
		v0 = w32(32);
		vl = w32(sz - 9);
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task t_reset();
		apb(1'b0, `OFS_CTRL, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, `OFS_PERIOD, 32'h0);
		check(rd, 32'h3e8);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, `OFS_SEQ, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		check({31'h0, er}, 32'h1);
		check(rd, 32'h0);
		check(activity_lamp, 32'h1);
	endtask
	task t_modes();
		int start;
		apb(1'b1, `OFS_CTRL, 32'h1);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check(rd, 32'h3);
		apb(1'b1, `OFS_CTRL, 32'h0);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check(rd, 32'h0);
		start = frame_sink_inst.frames_done;
		apb(1'b1, `OFS_FETCH, 32'h0);
		repeat (60) @(posedge clk);
		check(frame_sink_inst.frames_done, start);
	endtask
	task t_empty();
		int n;
		logic [31:0] a, b;
		slow <= 1'b1;
		apb(1'b1, `OFS_PERIOD, 32'h0);
		apb(1'b1, `OFS_CTRL, 32'h2);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check(rd, 32'h5);
		fetch_frame(n, a, b);
		check(n, 32'h0);
		for (int i = 12; i < 28; i++)
			check(frame_sink_inst.bytes_q[i], 32'h0);
		slow <= 1'b0;
	endtask
	task t_bulk();
		int n;
		logic [31:0] a, b, c, d;
		apb(1'b1, `OFS_CTRL, 32'h0);
		// 2 ms keeps the store far below its limit while a long frame is in flight
		apb(1'b1, `OFS_PERIOD, 32'h2);
		apb(1'b1, `OFS_CTRL, 32'h2);
		apb(1'b0, `OFS_SEQ, 32'h0);
		check(rd, 32'h0);
		rd = 32'h0;
		while (rd[29:16] <= 14'd1000) apb(1'b0, `OFS_STATUS, 32'h0);
		fetch_frame(n, a, b);
		check(n, 32'd1000);
		check(w32(16), 32'h0);
		check(w32(20), 32'h2);
		fetch_frame(n, c, d);
		check(n, 32'd1000);
		check(c - b, 32'h8);
		check(w32(16), 32'h1);
		check(lamp_low, 32'h1);
	endtask
	task t_stop();
		remote_en <= 1'b0;
		@(posedge clk);
		panel_stop <= 1'b1;
		@(posedge clk);
		panel_stop <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check({rd[29:16], rd[0]}, 32'h0);
		check(activity_lamp, 32'h1);
		apb(1'b1, `OFS_CTRL, 32'h2);
		apb(1'b0, `OFS_SEQ, 32'h0);
		check(rd, 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_modes();
		t_empty();
		t_bulk();
		t_stop();
		complete_run();
	end
endmodule // measurement_log_buffer_framer_test
